// [logic/cig_pkg.sv]
package cig_pkg;

  // option register byte offsets
  localparam logic [3:0] CIG_OPT_OFS    = 4'h0;   // option enables
  localparam logic [3:0] CIG_STAT_OFS   = 4'h4;   // status, read only
  localparam logic [3:0] CIG_FRAME_OFS  = 4'h8;   // configuration frame push

  // option register field positions
  localparam int CIG_OPT_CLK  = 0;   // external start-up clock enable
  localparam int CIG_OPT_INIT = 1;   // init-complete output enable
  localparam int CIG_OPT_OE   = 2;   // chip-wide output enable
  localparam int CIG_OPT_CLR  = 3;   // chip-wide clear enable
  localparam int CIG_OPT_W    = 4;

  // status field positions
  localparam int CIG_ST_CFG   = 0;   // idle or configuration in progress
  localparam int CIG_ST_INIT  = 1;   // initialization running
  localparam int CIG_ST_USER  = 2;   // user mode
  localparam int CIG_ST_IOEN  = 3;   // global io enable after override
  localparam int CIG_ST_CLR   = 4;   // global clear asserted
  localparam int CIG_ST_W     = 5;

  localparam logic [CIG_OPT_W-1:0] CIG_OPT_RST = 4'h0;
  localparam logic [31:0]          CIG_ZERO32  = 32'h0000_0000;

  // initialization length in ticks: start-up clock rises, or system clock cycles with the clock option off
  localparam int CIG_INIT_TICKS = 16;

  typedef enum logic [1:0] {
    CIG_IDLE = 2'b00,   // restart held or waiting for first frame
    CIG_CFG  = 2'b01,   // receiving configuration frames
    CIG_INIT = 2'b10,   // initialization countdown
    CIG_USER = 2'b11    // user mode
  } cig_state_t;

endpackage

// [logic/cig_config_init.sv]
`timescale 1ns/1ps
`default_nettype none

module cig_config_init
  import cig_pkg::*;
#(
  parameter int FRAME_WORDS = 4,              // words per configuration frame
  parameter int INIT_TICKS  = CIG_INIT_TICKS  // initialization length
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // configuration restart pin
  input  wire logic        config_restart_n,
  // start-up clock pin
  input  wire logic        user_startup_clock_i,
  output logic             user_startup_clock_o,
  output logic             user_startup_clock_oe_n,
  output logic             user_startup_clock_pu,
  // init-complete pin, open drain
  input  wire logic        init_done_i,
  output logic             init_done_o,
  output logic             init_done_oe_n,
  output logic             init_done_pu,
  // chip-wide output enable pin
  input  wire logic        chipwide_output_enable_i,
  output logic             chipwide_output_enable_o,
  output logic             chipwide_output_enable_oe_n,
  output logic             chipwide_output_enable_pu,
  // chip-wide clear pin
  input  wire logic        chipwide_clear_n_i,
  output logic             chipwide_clear_n_o,
  output logic             chipwide_clear_n_oe_n,
  output logic             chipwide_clear_n_pu,
  // user io path for pins whose option is off
  output logic      [3:0]  user_pin_in,
  input  wire logic [3:0]  user_pin_out,
  input  wire logic [3:0]  user_pin_oe_n,
  // global overrides to the fabric
  output logic             global_io_enable,
  output logic             global_clear,
  output logic             user_mode
);

  localparam int CW = $clog2(INIT_TICKS + 1);
  localparam int FW = $clog2(FRAME_WORDS + 1);

  // reset synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // pin synchronisers: bit0 restart, 1 clock, 2 oe, 3 clear, 4 status readback
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 5'h1f;   // idle-high levels, avoids false clear at start
      pin_s2_r <= 5'h1f;
    end else begin
      pin_s1_r <= {init_done_i, chipwide_clear_n_i, chipwide_output_enable_i,
                   user_startup_clock_i, config_restart_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire logic restart_n_s = pin_s2_r[0];
  wire logic uclk_s      = pin_s2_r[1];
  wire logic oe_s        = pin_s2_r[2];
  wire logic clrn_s      = pin_s2_r[3];

  // option register, loaded by the first frame word
  logic [CIG_OPT_W-1:0] opt_r;
  logic                 opt_loaded_r;   // option bits programmed
  cig_state_t           state_r;
  logic [FW-1:0]        word_cnt_r;     // words seen in the current frame
  logic [CW-1:0]        init_cnt_r;     // initialization ticks remaining
  logic                 uclk_d_r;       // start-up clock edge detect

  wire logic wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
  wire logic opt_wr   = wb_wr && (wb_adr_i == CIG_OPT_OFS) && (state_r != CIG_USER);
  wire logic frame_wr = wb_wr && (wb_adr_i == CIG_FRAME_OFS);
  wire logic uclk_rise = uclk_s && !uclk_d_r;
  // initialization pace: external clock edge or every internal cycle
  wire logic init_tick = opt_r[CIG_OPT_CLK] ? uclk_rise : 1'b1;

  // start-up clock edge detector, reads only the second stage
  // resets to the synchroniser's reset level so no false rise follows reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) uclk_d_r <= 1'b1;
    else        uclk_d_r <= uclk_s;
  end

  // options: writable only before user mode, cleared by restart
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opt_r        <= CIG_OPT_RST;
      opt_loaded_r <= 1'b0;
    end else if (!restart_n_s) begin
      opt_r        <= CIG_OPT_RST;
      opt_loaded_r <= 1'b0;
    end else if (opt_wr) begin
      opt_r <= wb_dat_i[CIG_OPT_W-1:0];
    end else if (frame_wr && state_r == CIG_IDLE) begin
      opt_r        <= wb_dat_i[CIG_OPT_W-1:0];   // first frame carries options
      opt_loaded_r <= 1'b1;
    end
  end

  // configuration sequence
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= CIG_IDLE;
      word_cnt_r <= '0;
      init_cnt_r <= '0;
    end else if (!restart_n_s) begin
      state_r    <= CIG_IDLE;   // restart aborts everything
      word_cnt_r <= '0;
      init_cnt_r <= '0;
    end else begin
      unique case (state_r)
        CIG_IDLE: begin
          if (frame_wr) begin
            state_r    <= CIG_CFG;
            word_cnt_r <= FW'(1);
          end
        end
        CIG_CFG: begin
          if (frame_wr) begin
            if (word_cnt_r == FW'(FRAME_WORDS - 1)) begin
              state_r    <= CIG_INIT;
              init_cnt_r <= CW'(INIT_TICKS);
            end else begin
              word_cnt_r <= word_cnt_r + FW'(1);
            end
          end
        end
        CIG_INIT: begin
          if (init_tick) begin
            if (init_cnt_r <= CW'(1)) state_r <= CIG_USER;
            else                      init_cnt_r <= init_cnt_r - CW'(1);
          end
        end
        CIG_USER: begin
          state_r <= CIG_USER;
        end
      endcase
    end
  end

  // pin functions; a pin is dedicated only with its option on
  wire logic dedicated_clk  = opt_r[CIG_OPT_CLK];
  wire logic dedicated_init = opt_r[CIG_OPT_INIT];
  wire logic dedicated_oe   = opt_r[CIG_OPT_OE];
  wire logic dedicated_clr  = opt_r[CIG_OPT_CLR];
  wire logic in_user        = (state_r == CIG_USER);
  wire logic [3:0] dedic    = {dedicated_clr, dedicated_oe, dedicated_init, dedicated_clk};

  // status driven low from option load until initialization ends
  wire logic init_pull_low = dedicated_init && opt_loaded_r && restart_n_s
                             && !in_user;

  // user io passthrough: tri-stated with pull-up until user mode
  // fabric sees the synchronised copies; two cycles of lag buys no metastable reads
  wire logic [3:0] pin_in_sync = {pin_s2_r[3], pin_s2_r[2], pin_s2_r[4], pin_s2_r[1]};
  logic [3:0] u_oe_n;
  logic [3:0] u_pu;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      u_oe_n[i] = dedic[i] || !in_user || user_pin_oe_n[i] || !global_io_enable;
      u_pu[i]   = !dedic[i] && !in_user;
    end
  end
  assign user_pin_in = pin_in_sync & ~dedic;

  assign user_startup_clock_o        = user_pin_out[0];
  assign user_startup_clock_oe_n     = u_oe_n[0];
  assign user_startup_clock_pu       = u_pu[0];
  // open drain: value low only, enable low only to pull low
  assign init_done_o    = dedicated_init ? 1'b0 : user_pin_out[1];
  assign init_done_oe_n = dedicated_init ? !init_pull_low : u_oe_n[1];
  assign init_done_pu   = u_pu[1];
  assign chipwide_output_enable_o    = user_pin_out[2];
  assign chipwide_output_enable_oe_n = u_oe_n[2];
  assign chipwide_output_enable_pu   = u_pu[2];
  assign chipwide_clear_n_o          = user_pin_out[3];
  assign chipwide_clear_n_oe_n       = u_oe_n[3];
  assign chipwide_clear_n_pu         = u_pu[3];

  // global overrides, active only with their options on
  assign global_io_enable = dedicated_oe ? oe_s : 1'b1;
  assign global_clear     = dedicated_clr && !clrn_s;
  assign user_mode        = in_user;

  // wishbone: registered ack one cycle after the request, then drop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= CIG_ZERO32;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          CIG_OPT_OFS:  wb_dat_o <= {{(32-CIG_OPT_W){1'b0}}, opt_r};
          CIG_STAT_OFS: wb_dat_o <= {{(32-CIG_ST_W){1'b0}}, global_clear, global_io_enable,
                                     in_user, state_r == CIG_INIT,
                                     state_r == CIG_CFG || state_r == CIG_IDLE};
          default:      wb_dat_o <= CIG_ZERO32;   // unmapped and frame read as zero
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [testbench/cig_config_init_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cig_config_init_assertions (
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // pins and fabric side
  input wire logic       config_restart_n,
  input wire logic       init_done_o,
  input wire logic       init_done_oe_n,
  input wire logic       user_startup_clock_oe_n,
  input wire logic       chipwide_output_enable_i,
  input wire logic       chipwide_output_enable_oe_n,
  input wire logic       chipwide_clear_n_i,
  input wire logic       chipwide_clear_n_oe_n,
  input wire logic [3:0] user_pin_in,
  input wire logic       global_io_enable,
  input wire logic       global_clear,
  input wire logic       user_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // restart held long enough to cross the synchroniser and reach idle
  sequence s_restart_held; !config_restart_n [*4]; endsequence
  a_od_low_only: assert property (!init_done_oe_n && !user_mode |-> !init_done_o)
    else $error("status pin driven high");
  a_restart_release: assert property (s_restart_held |-> init_done_oe_n && !user_mode)
    else $error("status pin not released under restart");
  a_release_at_user: assert property ($rose(user_mode) |-> init_done_oe_n)
    else $error("status pin held at user mode entry");
  a_low_before_user: assert property ($fell(init_done_oe_n) |-> !user_mode)
    else $error("status pin pulled low in user mode");
  a_dedicated_in_zero: assert property (!init_done_oe_n && !user_mode |-> user_pin_in[1] == 1'b0)
    else $error("dedicated pin leaks to fabric");
  a_cfg_pins_tristate: assert property (!user_mode |-> user_startup_clock_oe_n &&
    chipwide_output_enable_oe_n && chipwide_clear_n_oe_n) else $error("pin driven during configuration");
  // the synchroniser may add one edge, so either past sample may be the cause
  a_oe_from_pin: assert property ($fell(global_io_enable) |->
    !$past(chipwide_output_enable_i, 2) || !$past(chipwide_output_enable_i, 3)) else $error("io disable without pin");
  a_clear_from_pin: assert property ($rose(global_clear) |->
    !$past(chipwide_clear_n_i, 2) || !$past(chipwide_clear_n_i, 3)) else $error("clear without pin");
endmodule
bind cig_config_init cig_config_init_assertions cig_config_init_assertions_i (
  .clock(clock), .resetn(resetn), .config_restart_n(config_restart_n), .init_done_o(init_done_o),
  .init_done_oe_n(init_done_oe_n), .user_startup_clock_oe_n(user_startup_clock_oe_n),
  .chipwide_output_enable_i(chipwide_output_enable_i), .chipwide_output_enable_oe_n(chipwide_output_enable_oe_n),
  .chipwide_clear_n_i(chipwide_clear_n_i), .chipwide_clear_n_oe_n(chipwide_clear_n_oe_n),
  .user_pin_in(user_pin_in), .global_io_enable(global_io_enable), .global_clear(global_clear), .user_mode(user_mode));
`default_nettype wire

// [testbench/cig_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cig_board_model (
  // device side of the status pin
  input wire logic init_done_o,
  input wire logic init_done_oe_n,
  // bench lets the start-up oscillator run
  input wire logic run_clk,
  // board side
  output logic     init_done_pin,
  output logic     startup_clk,
  output int       rises
);
  // test-port select tied quiet for the whole run
  logic test_sel_quiet;
  assign test_sel_quiet = 1'b1;
  // external pull-up: a released line reads high
  assign init_done_pin = init_done_oe_n ? 1'b1 : init_done_o;
  // oscillator unrelated to the system clock; parks low when stopped
  initial startup_clk = 1'b0;
  always #18.5 startup_clk = run_clk & ~startup_clk;
  // monitor takes each low-to-high edge as init complete
  // only a true 0 to 1 counts; the unknown-to-high step at power-up is not one
  logic pin_last;
  initial rises = 0;
  initial pin_last = 1'b1;
  always @(init_done_pin) begin
    if (pin_last === 1'b0 && init_done_pin === 1'b1) rises++;
    pin_last = init_done_pin;
  end
endmodule
`default_nettype wire

// [testbench/cig_config_init_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cig_config_init_tb_top;
  import cig_pkg::*;
  // short counts keep the run brief
  localparam int FW = 2;
  logic clock = 1'b0, resetn = 1'b0, cyc = 1'b0, we = 1'b0, rst_n = 1'b1, oe_pin = 1'b1, clr_pin = 1'b1;
  logic run_clk = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, dat_o, rd;
  logic ack, do_o, do_oe_n, pin, sclk, umode, gio, gclr;
  logic [3:0] upin;
  logic dpu;
  int rises, failures = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  cig_config_init #(.FRAME_WORDS(FW), .INIT_TICKS(2)) cig_config_init_i (
    .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .config_restart_n(rst_n),
    .user_startup_clock_i(sclk), .user_startup_clock_o(), .user_startup_clock_oe_n(), .user_startup_clock_pu(),
    .init_done_i(pin), .init_done_o(do_o), .init_done_oe_n(do_oe_n), .init_done_pu(dpu),
    .chipwide_output_enable_i(oe_pin), .chipwide_output_enable_o(), .chipwide_output_enable_oe_n(),
    .chipwide_output_enable_pu(), .chipwide_clear_n_i(clr_pin), .chipwide_clear_n_o(), .chipwide_clear_n_oe_n(),
    .chipwide_clear_n_pu(), .user_pin_in(upin), .user_pin_out(4'h0), .user_pin_oe_n(4'hF),
    .global_io_enable(gio), .global_clear(gclr), .user_mode(umode));
  cig_board_model cig_board_model_i (.init_done_o(do_o), .init_done_oe_n(do_oe_n), .run_clk(run_clk),
    .init_done_pin(pin), .startup_clk(sclk), .rises(rises));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle; ack is sampled at the edge, so read data is taken there too
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
    if (n >= 50) begin chk("ack", ack, 1'b1); tally_and_finish(); end
  endtask
  // bounded wait for user mode; the status line must read high with it
  task automatic wait_user;
    int n;
    n = 0;
    do begin @(posedge clock); n++; end while (umode !== 1'b1 && n < 400);
    chk("user_mode", umode, 1'b1);
    chk("status pin", pin, 1'b1);
    if (n >= 400) tally_and_finish();
  endtask
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    bus(1'b0, CIG_OPT_OFS, CIG_ZERO32);
    chk("options reset", rd, {28'h000_0000, CIG_OPT_RST});
    bus(1'b0, 4'hC, 32'hFFFF_FFFF);
    chk("unmapped read", rd, CIG_ZERO32);
    // run one: every option on, start-up clock held still at first
    for (int i = 0; i < FW; i++) begin
      bus(1'b1, CIG_FRAME_OFS, 32'h0000_000F);
      chk("status low", pin, 1'b0);
      chk("dedicated in", upin[1], 1'b0);
      chk("dedicated no pull-up", dpu, 1'b0);
    end
    repeat (40) @(posedge clock);
    chk("no start-up ticks", umode, 1'b0);
    run_clk <= 1'b1;
    wait_user();
    chk("monitor rises", rises, 32'h0000_0001);
    oe_pin <= 1'b0;
    clr_pin <= 1'b0;
    repeat (4) @(posedge clock);
    chk("io enable", gio, 1'b0);
    chk("clear", gclr, 1'b1);
    bus(1'b0, CIG_STAT_OFS, CIG_ZERO32);
    chk("status user", rd[CIG_ST_USER], 1'b1);
    oe_pin <= 1'b1;
    clr_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    chk("restart user", umode, 1'b0);
    chk("restart pin", pin, 1'b1);
    rst_n <= 1'b1;
    run_clk <= 1'b0;
    repeat (3) @(posedge clock);
    // run two: no option, pins stay user io and overrides are ignored
    for (int i = 0; i < FW; i++) begin
      bus(1'b1, CIG_FRAME_OFS, CIG_ZERO32);
      chk("released pin", pin, 1'b1);
      chk("user in", upin[1], 1'b1);
      chk("user io pull-up", dpu, 1'b1);
    end
    wait_user();
    oe_pin <= 1'b0;
    clr_pin <= 1'b0;
    repeat (4) @(posedge clock);
    chk("io enable off", gio, 1'b1);
    chk("clear off", gclr, 1'b0);
    bus(1'b1, CIG_OPT_OFS, 32'h0000_000F);
    bus(1'b0, CIG_OPT_OFS, CIG_ZERO32);
    chk("options locked", rd, CIG_ZERO32);
    tally_and_finish();
  end
endmodule
`default_nettype wire
